// file: rtl/dpw_pkg.sv
// constants, register map and carriers for the dual pwm block
// assumes a byte-wide register port with one-cycle read latency
package dpw_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_A_PERIOD    = 8'h9a;
   localparam logic [7:0] ADDR_A_DUTY_HIGH = 8'h9b;
   localparam logic [7:0] ADDR_B_PERIOD    = 8'h9c;
   localparam logic [7:0] ADDR_B_DUTY_HIGH = 8'h9d;
   localparam logic [7:0] ADDR_CONTROL     = 8'ha1;
   localparam logic [7:0] RST_PERIOD       = 8'hff;
   localparam logic [7:0] RST_DUTY_HIGH    = 8'h80;
   localparam logic [7:0] RST_CONTROL      = 8'h88;
   localparam logic [7:0] CONTROL_MASK     = 8'hff;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;
   // control field positions
   localparam int A_DL_LSB  = 0;
   localparam int A_CKS_LSB = 2;
   localparam int B_DL_LSB  = 4;
   localparam int B_CKS_LSB = 6;
   // ---------------------------------------------------------------
   // clock select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] CKS_DIV4 = 2'h0;
   localparam logic [1:0] CKS_DIV2 = 2'h1;
   localparam logic [1:0] CKS_SYS  = 2'h2;
   localparam logic [1:0] CKS_RC2  = 2'h3;
   typedef struct packed {
      logic [7:0] period;
      logic [9:0] duty;
      logic [1:0] clock_select;
   } dpw_chan_cfg_s;
endpackage : dpw_pkg

// file: rtl/dpw_tick_sel.sv
// per-channel tick enable chooser
// assumes div pulses and rc tick are one-cycle enables on i_clk_sys
`timescale 1ns/1ns
`default_nettype none
module dpw_tick_sel
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic [1:0] i_clock_select,
   input  wire logic       i_en_div2,
   input  wire logic       i_en_div4,
   input  wire logic       i_en_rc2,
   output logic            o_tick
);
   import dpw_pkg::*;
   logic next_tick;
   // -----------------------------------------------------------------
   // source selection
   // -----------------------------------------------------------------
   // select decode
   assign next_tick = (i_clock_select == CKS_DIV4) ? i_en_div4 :
                      (i_clock_select == CKS_DIV2) ? i_en_div2 :
                      (i_clock_select == CKS_SYS)  ? 1'b1 : i_en_rc2;
   // registered so the tick is glitch free for the counter
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         o_tick <= 1'b0;
      else
         o_tick <= next_tick;
endmodule : dpw_tick_sel
`default_nettype wire

// file: rtl/dpw_top.sv
// dual pwm register file with per-channel period/duty and clock select
// assumes a byte register port; rc doubled clock arrives as a sync enable
`timescale 1ns/1ns
`default_nettype none
module dpw_top
#(
   parameter int NCH = 2
)
(
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst,
   input  wire logic [7:0]             i_addr,
   input  wire logic [7:0]             i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [7:0]             o_rdata,
   input  wire logic                   i_rc2_tick,
   output var dpw_pkg::dpw_chan_cfg_s  o_cfg_a,
   output var dpw_pkg::dpw_chan_cfg_s  o_cfg_b,
   output logic      [1:0]             o_tick
);
   import dpw_pkg::*;
   // control byte has room for two channels' fields only
   if (NCH != 2)
   begin : g_bad_nch
      $error("dpw_top serves exactly two channels");
   end
   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [7:0] pwm_a_period;
   logic [7:0] pwm_a_duty_high;
   logic [7:0] pwm_b_period;
   logic [7:0] pwm_b_duty_high;
   logic [7:0] pwm_shared_control;
   logic [1:0] div_cnt;
   logic       en_div2;
   logic       en_div4;
   logic [7:0] next_rdata;
   wire sel_ap = i_addr == ADDR_A_PERIOD;
   wire sel_ad = i_addr == ADDR_A_DUTY_HIGH;
   wire sel_bp = i_addr == ADDR_B_PERIOD;
   wire sel_bd = i_addr == ADDR_B_DUTY_HIGH;
   wire sel_ct = i_addr == ADDR_CONTROL;
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         pwm_a_period <= RST_PERIOD;
      else if (i_wr && sel_ap)
         pwm_a_period <= i_wdata;
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         pwm_a_duty_high <= RST_DUTY_HIGH;
      else if (i_wr && sel_ad)
         pwm_a_duty_high <= i_wdata;
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         pwm_b_period <= RST_PERIOD;
      else if (i_wr && sel_bp)
         pwm_b_period <= i_wdata;
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         pwm_b_duty_high <= RST_DUTY_HIGH;
      else if (i_wr && sel_bd)
         pwm_b_duty_high <= i_wdata;
   // duty low bits and selects; reset sets both selects to 10
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         pwm_shared_control <= RST_CONTROL;
      else if (i_wr && sel_ct)
         pwm_shared_control <= i_wdata & CONTROL_MASK;
   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   assign next_rdata = sel_ap ? pwm_a_period :
                       sel_ad ? pwm_a_duty_high :
                       sel_bp ? pwm_b_period :
                       sel_bd ? pwm_b_duty_high :
                       sel_ct ? pwm_shared_control : READ_UNMAPPED;
   // data held only in the cycle after the read strobe
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         o_rdata <= READ_UNMAPPED;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= READ_UNMAPPED;
   // -----------------------------------------------------------------
   // config outputs
   // -----------------------------------------------------------------
   // ten-bit duty assembly for channels a and b
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
      begin
         o_cfg_a <= '{RST_PERIOD, {RST_DUTY_HIGH, 2'h0}, CKS_SYS};
         o_cfg_b <= '{RST_PERIOD, {RST_DUTY_HIGH, 2'h0}, CKS_SYS};
      end
      else
      begin
         o_cfg_a <= '{pwm_a_period,
                      {pwm_a_duty_high, pwm_shared_control[A_DL_LSB +: 2]},
                      pwm_shared_control[A_CKS_LSB +: 2]};
         o_cfg_b <= '{pwm_b_period,
                      {pwm_b_duty_high, pwm_shared_control[B_DL_LSB +: 2]},
                      pwm_shared_control[B_CKS_LSB +: 2]};
      end
   // -----------------------------------------------------------------
   // dividers and per-channel tick
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         div_cnt <= 2'h0;
      else
         div_cnt <= div_cnt + 2'h1;
   assign en_div2 = div_cnt[0];
   assign en_div4 = &div_cnt;
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         dpw_tick_sel u_sel
         (
            .i_clk_sys      (i_clk_sys),
            .i_rst          (i_rst),
            .i_clock_select (pwm_shared_control[(g*(B_CKS_LSB - A_CKS_LSB)
                                                 + A_CKS_LSB) +: 2]),
            .i_en_div2      (en_div2),
            .i_en_div4      (en_div4),
            .i_en_rc2       (i_rc2_tick),
            .o_tick         (o_tick[g])
         );
      end
   endgenerate
endmodule : dpw_top
`default_nettype wire

// file: tb/dpw_properties.sv
// checker for dpw_top register writes and their configuration outputs
// assumes it is bound to dpw_top; a write shows on o_cfg two edges later
`timescale 1ns/1ns
`default_nettype none
module dpw_properties
(
   input wire logic                   i_clk_sys,
   input wire logic                   i_rst,
   input wire logic [7:0]             i_addr,
   input wire logic [7:0]             i_wdata,
   input wire logic                   i_wr,
   input wire dpw_pkg::dpw_chan_cfg_s o_cfg_a,
   input wire dpw_pkg::dpw_chan_cfg_s o_cfg_b,
   input wire logic [1:0]             o_tick
);
   import dpw_pkg::*;
   logic [7:0] wd1;
   logic [7:0] wd2;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // write data delayed to line up with the output lag
   always_ff @(posedge i_clk_sys)
   begin
      wd1 <= i_wdata;
      wd2 <= wd1;
   end
   property p_a_per;
      i_wr && i_addr == ADDR_A_PERIOD |-> ##2 o_cfg_a.period == wd2;
   endproperty
   a_a_per: assert property (p_a_per) else $error("a period wrong");
   property p_b_per;
      i_wr && i_addr == ADDR_B_PERIOD |-> ##2 o_cfg_b.period == wd2;
   endproperty
   a_b_per: assert property (p_b_per) else $error("b period wrong");
   property p_a_dh;
      i_wr && i_addr == ADDR_A_DUTY_HIGH |-> ##2 o_cfg_a.duty[9:2] == wd2;
   endproperty
   a_a_dh: assert property (p_a_dh) else $error("a duty high wrong");
   property p_a_dl;
      i_wr && i_addr == ADDR_CONTROL |-> ##2 o_cfg_a.duty[1:0] == wd2[1:0];
   endproperty
   a_a_dl: assert property (p_a_dl) else $error("a duty low wrong");
   property p_b_dh;
      i_wr && i_addr == ADDR_B_DUTY_HIGH |-> ##2 o_cfg_b.duty[9:2] == wd2;
   endproperty
   a_b_dh: assert property (p_b_dh) else $error("b duty high wrong");
   property p_b_dl;
      i_wr && i_addr == ADDR_CONTROL |-> ##2 o_cfg_b.duty[1:0] == wd2[5:4];
   endproperty
   a_b_dl: assert property (p_b_dl) else $error("b duty low wrong");
   property p_cks;
      i_wr && i_addr == ADDR_CONTROL |-> ##2
         o_cfg_a.clock_select == wd2[3:2] && o_cfg_b.clock_select == wd2[7:6];
   endproperty
   a_cks: assert property (p_cks) else $error("clock select wrong");
   c_ctl: cover property (i_wr && i_addr == ADDR_CONTROL);
   c_dh: cover property (i_wr && i_addr == ADDR_B_DUTY_HIGH);
   c_tick: cover property (o_tick == 2'h3);
endmodule : dpw_properties
bind dpw_top dpw_properties u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_cfg_a(o_cfg_a),
   .o_cfg_b(o_cfg_b), .o_tick(o_tick));
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for dpw_top registers and tick selection
// assumes only the register port and the rc enable input
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import dpw_pkg::*;
   logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_rc2_tick = 0;
   logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, m [5];
   logic [7:0] ad [6] = '{8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'ha1, 8'h9e};
   dpw_chan_cfg_s o_cfg_a, o_cfg_b;
   logic [1:0] o_tick;
   int fail_count = 0, compares = 0, n0, n1;
   dpw_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_rc2_tick(i_rc2_tick), .o_cfg_a(o_cfg_a), .o_cfg_b(o_cfg_b),
      .o_tick(o_tick));
   initial forever #2 i_clk_sys = ~i_clk_sys;
   task chk(input logic [19:0] got, input logic [19:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one access; index 5 is an unmapped address that must read zero
   task acc(input logic w, input int i, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= ad[i];
      i_wdata <= d;
      i_rc2_tick <= 1'($urandom);
      @(posedge i_clk_sys);
      i_wr <= 0;
      i_rd <= 0;
      if (w && i < 5) m[i] = d;
      @(negedge i_clk_sys);
      if (!w) chk(o_rdata, i < 5 ? m[i] : 8'h00);
   endtask : acc
   function automatic logic [19:0] cfg(input int c);
      logic [7:0] k;
      k = m[4] >> (4 * c);
      return {m[2 * c], m[2 * c + 1], k[1:0], k[3:2]};
   endfunction : cfg
   // ticks expected in eight cycles per select; 3 means rc low, 4 rc high
   function automatic logic [7:0] ticks(input int k);
      return 8'(k == 0 ? 2 : k == 1 ? 4 : k == 3 ? 0 : 8);
   endfunction : ticks
   task close_out;
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   initial
   begin
      void'($urandom(60318));
      m = '{8'hff, 8'h80, 8'hff, 8'h80, 8'h88};
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 0;
      for (int i = 0; i < 6; i++) acc(0, i, 8'h00);
      repeat (60)
      begin
         chk(o_cfg_a, cfg(0));
         chk(o_cfg_b, cfg(1));
         acc(1, $urandom % 6, 8'($urandom));
         acc(0, $urandom % 6, 8'h00);
      end
      // mid-run reset must bring back every reset value
      @(posedge i_clk_sys);
      i_rst <= 1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 0;
      m = '{RST_PERIOD, RST_DUTY_HIGH, RST_PERIOD, RST_DUTY_HIGH, RST_CONTROL};
      for (int i = 0; i < 6; i++) acc(0, i, 8'h00);
      chk(o_cfg_a, cfg(0));
      chk(o_cfg_b, cfg(1));
      // each select in turn; doubled-rc silent with rc low, follows it with rc high
      for (int k = 0; k < 5; k++)
      begin
         acc(1, 4, {2'(k > 3 ? 3 : k), 2'h0, 2'(k > 3 ? 3 : k), 2'h0});
         @(posedge i_clk_sys);
         i_rc2_tick <= (k == 4);
         repeat (4) @(posedge i_clk_sys);
         n0 = 0;
         n1 = 0;
         repeat (8)
         begin
            @(negedge i_clk_sys);
            n0 += o_tick[0];
            n1 += o_tick[1];
         end
         chk({n1[7:0], n0[7:0]}, {2{ticks(k)}});
      end
      close_out();
   end
endmodule : tb_top
`default_nettype wire
